/* hw/gain_and_clock_phase_regs.sv */
// Write-only gain and sample clock phase registers behind a classic Wishbone slave
//
// Overview of operation
// - Gain word sits in bits 15:7, index b
// - Gain code maps 560 to 839 mV linearly
// - Gain word resets to nominal 1_0000_0000
// - Gain write applies without calibration
// - Fine delay code in bits 15:8, index e
// - Fine delay code resets to zero
// - Bit 15 at index f inverts clock
// - Coarse delay bits 14:10, 65 ps steps
// - Intermediate delay bits 9:7, 11 ps steps
// - Coarse and intermediate delays add, about 2.1 ns
// - Register gain reaches q_gain_word_o only in extended control mode; q_span_mv_o follows it in both modes
`timescale 1ns/100ps
module gain_and_clock_phase_regs
   import gain_phase_pkg::*;
#(
   parameter int ADR_W = 6
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Mode
   input wire logic extended_mode_i,
   // Converter settings
   output logic [GAIN_W-1:0] q_gain_word_o,
   output logic [SPAN_MV_W-1:0] q_span_mv_o,
   output logic fs_pin_select_o,
   output clock_phase_s clock_phase_o,
   output logic [DELAY_PS_W-1:0] coarse_inter_delay_ps_o
);
   // -------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------
   if (ADR_W < 6) begin : g_adr_check
      $error("ADR_W must be at least 6 to reach index f");
   end

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [SPAN_MV_W-1:0] span_mv(input logic [GAIN_W-1:0] code);
      logic [19:0] prod;
      prod = 20'(code) * 20'(SPAN_RANGE_MV);
      return SPAN_MV_W'(SPAN_MIN_MV) + SPAN_MV_W'(prod >> GAIN_W);
   endfunction

   function automatic logic [DELAY_PS_W-1:0] delay_ps(input logic [COARSE_W-1:0] c,
                                                      input logic [INTER_W-1:0] i);
      return DELAY_PS_W'(c) * DELAY_PS_W'(COARSE_STEP_PS)
           + DELAY_PS_W'(i) * DELAY_PS_W'(INTER_STEP_PS);
   endfunction

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   logic req;
   logic wr;
   logic hit_gain;
   logic hit_fine;
   logic hit_pol;
   logic [GAIN_W-1:0] gain_r;
   clock_phase_s phase_r;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;

   always_comb begin
      hit_gain = 1'b0;
      hit_fine = 1'b0;
      hit_pol = 1'b0;
      if (wb_adr_i[1:0] != 2'h0) begin
         hit_gain = 1'b0;
      end else if (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(IDX_Q_GAIN)) begin
         hit_gain = 1'b1;
      end else if (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(IDX_FINE_DELAY)) begin
         hit_fine = 1'b1;
      end else if (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(IDX_POL_COARSE)) begin
         hit_pol = 1'b1;
      end
   end

   // Every access is acknowledged one cycle later, mapped or not
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Nothing is readable; host keeps a shadow copy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // -------------------------------------------------------------------
   // Gain register
   // -------------------------------------------------------------------
   // Low bits must-be-ones are dropped; lane 0 holds only the gain LSB
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_r <= RST_Q_GAIN[15:GAIN_LSB];
      end else if (wr && hit_gain) begin
         if (wb_sel_i[1]) begin
            gain_r[GAIN_W-1:1] <= wb_dat_i[15:8];
         end
         if (wb_sel_i[0]) begin
            gain_r[0] <= wb_dat_i[GAIN_LSB];
         end
      end
   end

   // -------------------------------------------------------------------
   // Phase registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r.fine <= RST_FINE_DELAY[15:FINE_LSB];
      end else if (wr && hit_fine && wb_sel_i[1]) begin
         phase_r.fine <= wb_dat_i[15:FINE_LSB];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r.invert <= RST_POL_COARSE[INVERT_BIT];
         phase_r.coarse <= RST_POL_COARSE[14:COARSE_LSB];
         phase_r.inter <= RST_POL_COARSE[9:INTER_LSB];
      end else if (wr && hit_pol) begin
         if (wb_sel_i[1]) begin
            phase_r.invert <= wb_dat_i[INVERT_BIT];
            phase_r.coarse <= wb_dat_i[14:COARSE_LSB];
            phase_r.inter[INTER_W-1:1] <= wb_dat_i[9:8];
         end
         if (wb_sel_i[0]) begin
            phase_r.inter[0] <= wb_dat_i[INTER_LSB];
         end
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Gain takes effect straight away; no calibration strobe exists here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_gain_word_o <= GAIN_NOMINAL;
         q_span_mv_o <= span_mv(GAIN_NOMINAL);
         fs_pin_select_o <= 1'b1;
      end else begin
         q_gain_word_o <= extended_mode_i ? gain_r : GAIN_NOMINAL;
         q_span_mv_o <= span_mv(gain_r);
         fs_pin_select_o <= !extended_mode_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_phase_o <= '0;
         coarse_inter_delay_ps_o <= '0;
      end else begin
         clock_phase_o <= phase_r;
         coarse_inter_delay_ps_o <= delay_ps(phase_r.coarse, phase_r.inter);
      end
   end
endmodule // gain_and_clock_phase_regs

/* hw/gain_phase_pkg.sv */
// Package of constants and types for the gain and clock phase register bank
package gain_phase_pkg;
   // -------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------------
   localparam logic [3:0] IDX_Q_GAIN = 4'hb;
   localparam logic [3:0] IDX_FINE_DELAY = 4'he;
   localparam logic [3:0] IDX_POL_COARSE = 4'hf;

   // -------------------------------------------------------------------
   // Field positions and widths
   // -------------------------------------------------------------------
   localparam int GAIN_W = 9;
   localparam int GAIN_LSB = 7;
   localparam int FINE_W = 8;
   localparam int FINE_LSB = 8;
   localparam int INVERT_BIT = 15;
   localparam int COARSE_W = 5;
   localparam int COARSE_LSB = 10;
   localparam int INTER_W = 3;
   localparam int INTER_LSB = 7;
   localparam int DELAY_PS_W = 12;
   localparam int SPAN_MV_W = 10;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [15:0] RST_Q_GAIN = 16'h807f;
   localparam logic [15:0] RST_FINE_DELAY = 16'h00ff;
   localparam logic [15:0] RST_POL_COARSE = 16'h007f;
   localparam logic [8:0] GAIN_NOMINAL = 9'h100;

   // -------------------------------------------------------------------
   // Analog scaling figures
   // -------------------------------------------------------------------
   localparam int SPAN_MIN_MV = 560;
   localparam int SPAN_RANGE_MV = 280;
   localparam int COARSE_STEP_PS = 65;
   localparam int INTER_STEP_PS = 11;

   typedef struct packed {
      logic invert;
      logic [COARSE_W-1:0] coarse;
      logic [INTER_W-1:0] inter;
      logic [FINE_W-1:0] fine;
   } clock_phase_s;
endpackage

/* test/gain_phase_chk.sv */
// Checker of handshake and setting outputs of the gain and clock phase bank
`timescale 1ns/100ps
module gain_phase_chk
   import gain_phase_pkg::*;
#(
   parameter int ADR_W = 6
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Settings
   input wire logic extended_mode_i,
   input wire logic [GAIN_W-1:0] q_gain_word_o,
   input wire logic [SPAN_MV_W-1:0] q_span_mv_o,
   input wire logic fs_pin_select_o,
   input wire clock_phase_s clock_phase_o,
   input wire logic [DELAY_PS_W-1:0] coarse_inter_delay_ps_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_follows: assert property (take |=> wb_ack_o) else $error("no ack");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_no_readback: assert property (wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero");
   a_reset_state: assert property ($past(rst_i) |-> clock_phase_o == '0 &&
      q_gain_word_o == GAIN_NOMINAL && q_span_mv_o == 10'h2bc) else $error("bad reset state");
   a_pin_mode: assert property (!$past(rst_i) |-> fs_pin_select_o == !$past(extended_mode_i)
      && ($past(extended_mode_i) || q_gain_word_o == GAIN_NOMINAL)) else $error("bad mode");
   a_span_map: assert property (!$past(rst_i) && $past(extended_mode_i) |->
      q_span_mv_o == SPAN_MV_W'(SPAN_MIN_MV + int'(q_gain_word_o) * SPAN_RANGE_MV / 512))
      else $error("bad span");
   a_delay_sum: assert property (coarse_inter_delay_ps_o == DELAY_PS_W'(
      clock_phase_o.coarse * COARSE_STEP_PS + clock_phase_o.inter * INTER_STEP_PS))
      else $error("bad delay");
   a_gain_write: assert property (take && wb_we_i && wb_adr_i == ADR_W'(6'h2c)
      && wb_sel_i[1:0] == 2'h3 && extended_mode_i ##1 extended_mode_i
      |=> q_gain_word_o == $past(wb_dat_i[15:7], 2)) else $error("gain not applied");
   a_fine_write: assert property (take && wb_we_i && wb_adr_i == ADR_W'(6'h38) && wb_sel_i[1]
      |-> ##2 clock_phase_o.fine == $past(wb_dat_i[15:8], 2)) else $error("fine not applied");
   c_gain_wr: cover property (take && wb_we_i && wb_adr_i == ADR_W'(6'h2c));
   c_read: cover property (take && !wb_we_i);
   c_misaligned: cover property (take && wb_adr_i[1:0] != 2'h0);
endmodule // gain_phase_chk

bind gain_and_clock_phase_regs gain_phase_chk #(.ADR_W(ADR_W)) u_gain_phase_chk (.clk_i,
   .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .extended_mode_i, .q_gain_word_o, .q_span_mv_o, .fs_pin_select_o, .clock_phase_o,
   .coarse_inter_delay_ps_o);

/* test/tb.sv */
// Self-checking bench for the gain and clock phase register bank
`timescale 1ns/100ps
module tb;
   import gain_phase_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic extended_mode_i = 1'b1;
   logic [5:0] wb_adr_i = 6'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic fs_pin_select_o;
   logic [8:0] q_gain_word_o;
   logic [8:0] g = 9'h100;
   logic [9:0] q_span_mv_o;
   logic [11:0] coarse_inter_delay_ps_o;
   clock_phase_s clock_phase_o;
   clock_phase_s p = '0;
   logic [48:0] q[$];
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc_n = 0;
   wire [48:0] seen = {q_gain_word_o, q_span_mv_o, fs_pin_select_o, clock_phase_o,
      coarse_inter_delay_ps_o};
   gain_and_clock_phase_regs u_gain_and_clock_phase_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .extended_mode_i,
      .q_gain_word_o, .q_span_mv_o, .fs_pin_select_o, .clock_phase_o, .coarse_inter_delay_ps_o);
   initial forever #5 clk_i = ~clk_i;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Model of the settings as the outputs should show them after a transfer
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
      input logic [3:0] s, input logic x);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, extended_mode_i} <= {2'b11, w, a, s, x};
      wb_dat_i <= {16'h0, d};
      if (w && a == 6'h2c) begin
         if (s[1]) g[8:1] = d[15:8];
         if (s[0]) g[0] = d[7];
      end
      if (w && a == 6'h38 && s[1]) p.fine = d[15:8];
      if (w && a == 6'h3c) begin
         if (s[1]) {p.invert, p.coarse, p.inter[2:1]} = d[15:8];
         if (s[0]) p.inter[0] = d[7];
      end
      q.push_back({x ? g : 9'h100, 10'(SPAN_MIN_MV + int'(g) * SPAN_RANGE_MV / 512), !x, p,
         12'(p.coarse * COARSE_STEP_PS + p.inter * INTER_STEP_PS)});
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   // Outputs settle one edge after the ack is seen
   always @(posedge clk_i) begin
      if (++cyc_n > 3000) begin
         error_cnt++;
         print_verdict();
      end
      if (wb_ack_o === 1'b1) begin
         #1 samples_checked++;
         if (seen !== q[0]) begin
            error_cnt++;
            $display("mismatch outputs expected %h seen %h", q[0], seen);
         end
         if (wb_dat_o !== 32'h0000_0000) begin
            error_cnt++;
            $display("mismatch wb_dat_o expected %h seen %h", 32'h0000_0000, wb_dat_o);
         end
         void'(q.pop_front());
      end
   end
   initial begin
      logic [8:0] gb [4] = '{9'h000, 9'h1ff, 9'h0c0, 9'h1c0};
      logic [5:0] at [5] = '{6'h2c, 6'h38, 6'h3c, 6'h30, 6'h2d};
      logic [5:0] a;
      void'($urandom(85));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, 6'h2c, 16'hffff, 4'hf, 1'b1);
      for (int i = 0; i < 4; i++) xfer(1'b1, 6'h2c, {gb[i], 7'h7f}, 4'hf, 1'b1);
      $display("test gain_bounds done");
      repeat (60) begin
         a = at[$urandom % 5];
         xfer(1'($urandom), a, 16'($urandom) | (a == 6'h38 ? 16'h00ff : 16'h007f),
            4'($urandom), 1'($urandom));
      end
      $display("test random_access done");
      repeat (2) @(posedge clk_i);
      print_verdict();
   end
endmodule // tb
